/* core/pdf_pkg.sv */
// Package for the packet framer: symbols, ordered sets, CRC constants, carriers
package pdf_pkg;
  // ****************************************
  // Symbol encoding between framer and coder
  // ****************************************
  // A symbol is a data nibble (is_k = 0) or a K-code (is_k = 1).
  localparam logic [3:0] PDF_K_SYNC1 = 4'h0;
  localparam logic [3:0] PDF_K_SYNC2 = 4'h1;
  localparam logic [3:0] PDF_K_SYNC3 = 4'h2;
  localparam logic [3:0] PDF_K_RST1  = 4'h3;
  localparam logic [3:0] PDF_K_RST2  = 4'h4;
  localparam logic [3:0] PDF_K_EOP   = 4'h5;
  localparam logic [3:0] PDF_K_ERR   = 4'hf;

  typedef struct packed {
    logic       is_k;
    logic [3:0] code;
  } pdf_sym_t;

  // Start sequence types, reported with each delivered packet
  typedef enum logic [2:0] {
    PDF_SOP    = 3'h0,
    PDF_SOP1   = 3'h1,
    PDF_SOP2   = 3'h2,
    PDF_SOP1_D = 3'h3,
    PDF_SOP2_D = 3'h4,
    PDF_NONE   = 3'h7
  } pdf_sop_t;

  // Four K-codes of each ordered set, first code in the low nibble
  localparam logic [15:0] PDF_OS_SOP    = {PDF_K_SYNC2, PDF_K_SYNC1, PDF_K_SYNC1, PDF_K_SYNC1};
  localparam logic [15:0] PDF_OS_SOP1   = {PDF_K_SYNC3, PDF_K_SYNC3, PDF_K_SYNC1, PDF_K_SYNC1};
  localparam logic [15:0] PDF_OS_SOP2   = {PDF_K_SYNC3, PDF_K_SYNC1, PDF_K_SYNC3, PDF_K_SYNC1};
  localparam logic [15:0] PDF_OS_SOP1_D = {PDF_K_SYNC3, PDF_K_RST2, PDF_K_RST2, PDF_K_SYNC1};
  localparam logic [15:0] PDF_OS_SOP2_D = {PDF_K_SYNC2, PDF_K_SYNC3, PDF_K_RST2, PDF_K_SYNC1};
  localparam int          PDF_OS_MIN    = 3;

  // ****************************************
  // CRC-32
  // ****************************************
  localparam logic [31:0] PDF_CRC_POLY  = 32'h04c11db7;
  localparam logic [31:0] PDF_CRC_INIT  = 32'hffffffff;
  localparam logic [31:0] PDF_CRC_RESID = 32'hc704dd7b;

  // ****************************************
  // Port role and contract state
  // ****************************************
  typedef enum logic [1:0] {
    PDF_ROLE_DFP   = 2'h0,
    PDF_ROLE_UFP   = 2'h1,
    PDF_ROLE_PLUG1 = 2'h2,
    PDF_ROLE_PLUG2 = 2'h3
  } pdf_role_t;

  typedef struct packed {
    pdf_role_t role;
    logic      explicit_contract;
    logic      sink;
  } pdf_cfg_t;

  typedef struct packed {
    logic     [7:0] data;
    logic           last;
  } pdf_byte_t;
endpackage

/* core/pdf_framer.sv */
// Packet framer: start-sequence filter, CRC-32 insert and check, EOP
`timescale 1ns/1ps
`default_nettype none
module pdf_framer (
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire pdf_pkg::pdf_cfg_t cfg,
  // Transmit request from the protocol side
  input  wire logic              tx_start,
  input  wire pdf_pkg::pdf_sop_t tx_sop,
  input  wire logic              tx_valid,
  input  wire pdf_pkg::pdf_byte_t tx_byte,
  input  wire logic              tx_abort,
  output logic                   tx_ready,
  output logic                   tx_busy,
  output logic                   tx_refused,
  // Symbols toward the coder
  output pdf_pkg::pdf_sym_t      sym_out,
  output logic                   sym_out_valid,
  input  wire logic              sym_out_ready,
  // Symbols from the decoder, one per cycle when valid
  input  wire pdf_pkg::pdf_sym_t sym_in,
  input  wire logic              sym_in_valid,
  input  wire logic              rx_idle,
  // Delivered bytes; packet counts only when rx_good pulses
  output pdf_pkg::pdf_byte_t     rx_byte,
  output logic                   rx_byte_valid,
  output logic                   rx_good,
  output logic                   rx_bad,
  output pdf_pkg::pdf_sop_t      rx_sop
);
  import pdf_pkg::*;

  // ****************************************
  // Shared CRC step, one byte, LSB first
  // ****************************************
  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] b);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r[31] ^ b[i]) ? ((r << 1) ^ PDF_CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  // Sent field: inverted remainder, bit i to 31-i, LSB of field first on the wire
  function automatic logic [31:0] crc_field(input logic [31:0] c);
    logic [31:0] f;
    f = 32'h0;
    for (int i = 0; i < 32; i++) begin
      f[31 - i] = ~c[i];
    end
    return f;
  endfunction

  // Start-sequence policy: which types this role may send and accept
  function automatic logic sop_allowed(input pdf_cfg_t c, input pdf_sop_t s);
    logic ok;
    ok = 1'b0;
    case (c.role)
      PDF_ROLE_PLUG1: ok = (s == PDF_SOP1);
      PDF_ROLE_PLUG2: ok = (s == PDF_SOP2);
      PDF_ROLE_UFP:   ok = (s == PDF_SOP) ||
                           ((s == PDF_SOP1) && !c.explicit_contract);
      PDF_ROLE_DFP:   ok = (s == PDF_SOP) || (s == PDF_SOP1) || (s == PDF_SOP2);
      default:        ok = 1'b0;
    endcase
    if (c.sink && !c.explicit_contract && s == PDF_SOP1) begin
      ok = 1'b0;
    end
    return ok;
  endfunction

  // ****************************************
  // Receive: ordered set matching
  // ****************************************
  logic [15:0] os_q;
  logic [2:0]  os_cnt_q;
  logic [4:0]  os_hit;
  wire [3:0]   os_code = sym_in.is_k ? sym_in.code : PDF_K_ERR;
  wire [15:0]  os_nxt  = os_q | (16'(os_code) << {os_cnt_q[1:0], 2'b00});
  localparam logic [15:0] OS_TAB [5] = '{PDF_OS_SOP, PDF_OS_SOP1, PDF_OS_SOP2,
                                         PDF_OS_SOP1_D, PDF_OS_SOP2_D};
  genvar g;
  generate
    for (g = 0; g < 5; g++) begin : g_os
      wire [2:0] m0 = {2'b0, os_nxt[3:0]   == OS_TAB[g][3:0]};
      wire [2:0] m1 = {2'b0, os_nxt[7:4]   == OS_TAB[g][7:4]};
      wire [2:0] m2 = {2'b0, os_nxt[11:8]  == OS_TAB[g][11:8]};
      wire [2:0] m3 = {2'b0, os_nxt[15:12] == OS_TAB[g][15:12]};
      assign os_hit[g] = (m0 + m1 + m2 + m3) >= 3'(PDF_OS_MIN);
    end
  endgenerate
  // Debug sets carry no defined use, so they are matched but never accepted
  // Set judged as its fourth code arrives, so no data nibble is lost
  wire      os_done  = sym_in_valid && (os_cnt_q == 3'h3);
  wire [2:0] os_type = os_hit[0] ? PDF_SOP : os_hit[1] ? PDF_SOP1 : os_hit[2] ? PDF_SOP2 :
                       os_hit[3] ? PDF_SOP1_D : os_hit[4] ? PDF_SOP2_D : PDF_NONE;
  wire      os_ok    = sop_allowed(cfg, pdf_sop_t'(os_type));

  // ****************************************
  // Receive: payload collection and check
  // ****************************************
  typedef enum logic [1:0] {R_HUNT = 2'b00, R_SOP = 2'b01, R_DATA = 2'b11, R_SKIP = 2'b10} pdf_rst_t;
  pdf_rst_t    rs_q;
  logic [31:0] rcrc_q;
  logic [3:0]  lo_q;
  logic        half_q;
  logic [2:0]  fill_q;
  wire         pipe_full = (fill_q == 3'h4);
  wire         in_k   = sym_in_valid && sym_in.is_k;
  wire         in_d   = sym_in_valid && !sym_in.is_k;
  wire         in_eop = in_k && sym_in.code == PDF_K_EOP;
  wire [7:0]   in_b   = {sym_in.code, lo_q};
  // Bytes lag four bytes so the four CRC bytes never reach the protocol side
  logic [7:0]  pipe_q [4];

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rs_q          <= R_HUNT;
      os_q          <= 16'h0;
      os_cnt_q      <= 3'h0;
      rcrc_q        <= PDF_CRC_INIT;
      lo_q          <= 4'h0;
      half_q        <= 1'b0;
      fill_q        <= 3'h0;
      rx_byte       <= '0;
      rx_byte_valid <= 1'b0;
      rx_good       <= 1'b0;
      rx_bad        <= 1'b0;
      rx_sop        <= PDF_NONE;
      for (int i = 0; i < 4; i++) pipe_q[i] <= 8'h0;
    end else begin
      rx_byte_valid <= 1'b0;
      rx_good       <= 1'b0;
      rx_bad        <= 1'b0;
      if (rx_idle && rs_q != R_HUNT) begin
        rs_q   <= R_HUNT;
        rx_bad <= (rs_q == R_DATA);
      end else begin
        case (rs_q)
          R_HUNT: if (in_k && sym_in.code != PDF_K_EOP) begin
            os_q     <= {12'h0, sym_in.code};
            os_cnt_q <= 3'h1;
            rs_q     <= R_SOP;
          end
          R_SOP: if (os_done) begin
            rcrc_q <= PDF_CRC_INIT;
            half_q <= 1'b0;
            fill_q <= 3'h0;
            rx_sop <= pdf_sop_t'(os_type);
            rs_q   <= os_ok ? R_DATA : R_SKIP;
          end else if (sym_in_valid) begin
            os_q     <= os_nxt;
            os_cnt_q <= os_cnt_q + 3'h1;
          end
          R_DATA: if (in_eop) begin
            rs_q    <= R_HUNT;
            rx_good <= (rcrc_q == PDF_CRC_RESID);
            rx_bad  <= (rcrc_q != PDF_CRC_RESID);
          end else if (in_k) begin
            rs_q   <= R_HUNT;
            rx_bad <= 1'b1;
          end else if (in_d) begin
            half_q <= ~half_q;
            lo_q   <= sym_in.code;
            if (half_q) begin
              rcrc_q <= crc_byte(rcrc_q, in_b);
              pipe_q[0] <= in_b;
              for (int i = 1; i < 4; i++) pipe_q[i] <= pipe_q[i-1];
              if (!pipe_full) fill_q <= fill_q + 3'h1;
              rx_byte.data  <= pipe_q[3];
              rx_byte.last  <= 1'b0;
              rx_byte_valid <= pipe_full;
            end
          end
          R_SKIP: if (in_eop || rx_idle) begin
            rs_q <= R_HUNT;
          end
          default: rs_q <= R_HUNT;
        endcase
      end
    end
  end

  // ****************************************
  // Transmit
  // ****************************************
  typedef enum logic [2:0] {T_IDLE = 3'b000, T_SOP = 3'b001, T_DATA = 3'b011,
                            T_CRC = 3'b010, T_EOP = 3'b110} pdf_tst_t;
  pdf_tst_t    ts_q;
  logic [31:0] tcrc_q;
  logic [31:0] tsh_q;
  logic [3:0]  tcnt_q;
  logic [15:0] tos_q;
  logic [7:0]  tb_q;
  logic        tlast_q;
  logic        thalf_q;
  logic        tfull_q;
  wire         adv      = !sym_out_valid || sym_out_ready;
  wire         take     = tx_ready && tx_valid;
  wire [15:0]  tos_sel  = (tx_sop == PDF_SOP1) ? PDF_OS_SOP1 :
                          (tx_sop == PDF_SOP2) ? PDF_OS_SOP2 : PDF_OS_SOP;
  wire         tx_allow = sop_allowed(cfg, tx_sop) &&
                          (tx_sop == PDF_SOP || tx_sop == PDF_SOP1 || tx_sop == PDF_SOP2);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ts_q          <= T_IDLE;
      tcrc_q        <= PDF_CRC_INIT;
      tsh_q         <= 32'h0;
      tcnt_q        <= 4'h0;
      tos_q         <= 16'h0;
      tb_q          <= 8'h0;
      tlast_q       <= 1'b0;
      thalf_q       <= 1'b0;
      tfull_q       <= 1'b0;
      tx_ready      <= 1'b0;
      tx_busy       <= 1'b0;
      tx_refused    <= 1'b0;
      sym_out       <= '0;
      sym_out_valid <= 1'b0;
    end else begin
      tx_refused <= 1'b0;
      if (sym_out_valid && sym_out_ready) sym_out_valid <= 1'b0;
      // Intake decoupled from symbol stalls, so a taken byte is lost only when tx_abort drops it before it is sent
      if (take) begin
        tb_q     <= tx_byte.data;
        tlast_q  <= tx_byte.last;
        tfull_q  <= 1'b1;
        tx_ready <= 1'b0;
        tcrc_q   <= crc_byte(tcrc_q, tx_byte.data);
      end
      if (tx_abort && ts_q != T_IDLE && ts_q != T_EOP && adv) begin
        ts_q          <= T_EOP;
        tx_ready      <= 1'b0;
        tfull_q       <= 1'b0;
        thalf_q       <= 1'b0;
        sym_out       <= '{is_k: 1'b1, code: PDF_K_EOP};
        sym_out_valid <= 1'b1;
      end else if (adv) begin
        case (ts_q)
          T_IDLE: if (tx_start) begin
            tx_refused <= !tx_allow;
            tx_busy    <= tx_allow;
            tos_q      <= tos_sel;
            tcnt_q     <= 4'h4;
            tfull_q    <= 1'b0;
            tcrc_q     <= PDF_CRC_INIT;
            ts_q       <= tx_allow ? T_SOP : T_IDLE;
          end
          T_SOP: begin
            sym_out       <= '{is_k: 1'b1, code: tos_q[3:0]};
            sym_out_valid <= 1'b1;
            tos_q         <= tos_q >> 4;
            tcnt_q        <= tcnt_q - 4'h1;
            thalf_q       <= 1'b0;
            if (tcnt_q == 4'h1) begin
              ts_q     <= T_DATA;
              tx_ready <= 1'b1;
            end
          end
          T_DATA: if (tfull_q && !thalf_q) begin
            sym_out       <= '{is_k: 1'b0, code: tb_q[3:0]};
            sym_out_valid <= 1'b1;
            thalf_q       <= 1'b1;
          end else if (thalf_q) begin
            sym_out       <= '{is_k: 1'b0, code: tb_q[7:4]};
            sym_out_valid <= 1'b1;
            thalf_q       <= 1'b0;
            tfull_q       <= 1'b0;
            tx_ready      <= !tlast_q;
            if (tlast_q) begin
              ts_q   <= T_CRC;
              tsh_q  <= crc_field(tcrc_q);
              tcnt_q <= 4'h8;
            end
          end
          T_CRC: begin
            sym_out       <= '{is_k: 1'b0, code: tsh_q[3:0]};
            sym_out_valid <= 1'b1;
            tsh_q         <= tsh_q >> 4;
            tcnt_q        <= tcnt_q - 4'h1;
            if (tcnt_q == 4'h1) ts_q <= T_EOP;
          end
          T_EOP: begin
            if (!(sym_out.is_k && sym_out.code == PDF_K_EOP)) begin
              sym_out       <= '{is_k: 1'b1, code: PDF_K_EOP};
              sym_out_valid <= 1'b1;
            end
            ts_q    <= T_IDLE;
            tx_busy <= 1'b0;
          end
          default: ts_q <= T_IDLE;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

/* dv/pdf_framer_sva.sv */
// Checker for the framer ports
`timescale 1ns/1ps
`default_nettype none
module pdf_framer_sva (
  input wire logic              clk,
  input wire logic              reset_n,
  input wire pdf_pkg::pdf_cfg_t cfg,
  input wire logic              tx_start,
  input wire pdf_pkg::pdf_sop_t tx_sop,
  input wire logic              tx_abort,
  input wire logic              tx_busy,
  input wire logic              tx_refused,
  input wire pdf_pkg::pdf_sym_t sym_out,
  input wire logic              sym_out_valid,
  input wire logic              sym_out_ready,
  input wire logic              rx_good,
  input wire logic              rx_bad
);
  import pdf_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic is_ufp;
  assign is_ufp = cfg.role == PDF_ROLE_UFP;
  // *****
  // Steps
  // *****
  sequence s_req(pdf_sop_t t);
    tx_start && !tx_busy && tx_sop == t;
  endsequence
  sequence s_eop_taken;
    sym_out_valid && sym_out_ready && sym_out.is_k && sym_out.code == PDF_K_EOP;
  endsequence
  chk_debug_refused: assert property (
    (s_req(PDF_SOP1_D) or s_req(PDF_SOP2_D)) |=> tx_refused) else $error("debug start sent");
  chk_ufp_no_sop2: assert property (
    is_ufp ##0 s_req(PDF_SOP2) |=> tx_refused) else $error("ufp sent double prime");
  chk_ufp_no_sop1: assert property (
    is_ufp && cfg.explicit_contract ##0 s_req(PDF_SOP1) |=> tx_refused)
    else $error("contracted ufp sent prime");
  chk_sink_no_sop1: assert property (
    cfg.sink && !cfg.explicit_contract ##0 s_req(PDF_SOP1) |=> tx_refused)
    else $error("uncontracted sink sent prime");
  chk_refuse_silent: assert property (
    tx_refused |-> !sym_out_valid && !tx_busy) else $error("refused start went out");
  chk_prime_head: assert property (
    cfg.role == PDF_ROLE_DFP ##0 s_req(PDF_SOP1) |->
      ##2 sym_out_valid && sym_out == {1'b1, PDF_K_SYNC1})
    else $error("prime start symbol wrong");
  chk_sym_hold: assert property (
    sym_out_valid && !sym_out_ready |=> sym_out_valid && $stable(sym_out))
    else $error("stalled symbol changed");
  chk_eop_last: assert property (
    s_eop_taken |-> ##[0:2] !tx_busy) else $error("packet went on after end");
  chk_abort_eop: assert property (
    tx_busy && tx_abort |-> ##[0:16] s_eop_taken) else $error("abort gave no end");
  chk_good_bad_excl: assert property (
    !(rx_good && rx_bad)) else $error("good and bad together");
endmodule
bind pdf_framer pdf_framer_sva u_sva (.clk(clk), .reset_n(reset_n), .cfg(cfg),
  .tx_start(tx_start), .tx_sop(tx_sop), .tx_abort(tx_abort), .tx_busy(tx_busy),
  .tx_refused(tx_refused), .sym_out(sym_out), .sym_out_valid(sym_out_valid),
  .sym_out_ready(sym_out_ready), .rx_good(rx_good), .rx_bad(rx_bad));
`default_nettype wire

/* dv/pdf_line_model.sv */
// Line-side model: symbol sink with stalls, symbol source
`timescale 1ns/1ps
`default_nettype none
module pdf_line_model (
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic              slow,
  input  wire pdf_pkg::pdf_sym_t sym_out,
  input  wire logic              sym_out_valid,
  output logic                   sym_out_ready,
  output pdf_pkg::pdf_sym_t      sym_in,
  output logic                   sym_in_valid
);
  import pdf_pkg::*;
  pdf_sym_t tx_q[$];
  pdf_sym_t rx_q[$];
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sym_out_ready <= 1'b0;
      sym_in_valid  <= 1'b0;
      sym_in        <= '0;
    end else begin
      // Slow mode holds ready low every other cycle
      sym_out_ready <= !slow || !sym_out_ready;
      if (sym_out_valid && sym_out_ready) begin
        tx_q.push_back(sym_out);
      end
      // One frame at a time, never overlapping
      if (rx_q.size() > 0) begin
        sym_in       <= rx_q.pop_front();
        sym_in_valid <= 1'b1;
      end else begin
        // Released line moves, never repeats the last symbol
        sym_in       <= pdf_sym_t'(~sym_in);
        sym_in_valid <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

/* dv/tb_pd_sop_framing_crc32.sv */
// Testbench for the packet framer
`timescale 1ns/1ps
`default_nettype none
module tb_pd_sop_framing_crc32;
  import pdf_pkg::*;
  localparam pdf_cfg_t C_DFP = '{PDF_ROLE_DFP, 1'b1, 1'b0};
  localparam pdf_cfg_t C_UFP = '{PDF_ROLE_UFP, 1'b1, 1'b0};
  localparam pdf_cfg_t C_SNK = '{PDF_ROLE_UFP, 1'b0, 1'b1};
  localparam pdf_cfg_t C_P1  = '{PDF_ROLE_PLUG1, 1'b0, 1'b0};
  localparam pdf_cfg_t C_P2  = '{PDF_ROLE_PLUG2, 1'b0, 1'b0};
  logic       clk = 1'b0;
  logic       reset_n = 1'b0;
  logic       slow = 1'b0;
  pdf_cfg_t   cfg = C_DFP;
  logic       tx_start = 1'b0;
  pdf_sop_t   tx_sop = PDF_SOP;
  logic       tx_valid = 1'b0;
  pdf_byte_t  tx_byte = '0;
  logic       tx_abort = 1'b0;
  logic       rx_idle = 1'b0;
  logic       tx_ready, tx_busy, tx_refused, sym_out_valid, sym_out_ready;
  logic       sym_in_valid, rx_byte_valid, rx_good, rx_bad;
  pdf_sym_t   sym_out, sym_in;
  pdf_byte_t  rx_byte;
  pdf_sop_t   rx_sop;
  int         mismatches = 0;
  int         tests_run = 0;
  int         n_good, n_bad;
  logic [7:0] rx_got[$];
  logic [7:0] pl[$] = '{8'ha1, 8'h5c, 8'h07, 8'hf3, 8'h80};
  pdf_sym_t   exp_q[$];
  always #25 clk = ~clk;
  pdf_framer u_dut (.clk(clk), .reset_n(reset_n), .cfg(cfg), .tx_start(tx_start),
    .tx_sop(tx_sop), .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_abort(tx_abort),
    .tx_ready(tx_ready), .tx_busy(tx_busy), .tx_refused(tx_refused), .sym_out(sym_out),
    .sym_out_valid(sym_out_valid), .sym_out_ready(sym_out_ready), .sym_in(sym_in),
    .sym_in_valid(sym_in_valid), .rx_idle(rx_idle), .rx_byte(rx_byte),
    .rx_byte_valid(rx_byte_valid), .rx_good(rx_good), .rx_bad(rx_bad), .rx_sop(rx_sop));
  pdf_line_model u_line (.clk(clk), .reset_n(reset_n), .slow(slow), .sym_out(sym_out),
    .sym_out_valid(sym_out_valid), .sym_out_ready(sym_out_ready), .sym_in(sym_in),
    .sym_in_valid(sym_in_valid));
  always @(posedge clk) begin
    if (rx_byte_valid) rx_got.push_back(rx_byte.data);
    if (rx_good) n_good++;
    if (rx_bad) n_bad++;
  end
  // *****
  // Helpers
  // *****
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  function automatic logic [15:0] os_of(input pdf_sop_t t);
    case (t)
      PDF_SOP1:   return {PDF_K_SYNC3, PDF_K_SYNC3, PDF_K_SYNC1, PDF_K_SYNC1};
      PDF_SOP2:   return {PDF_K_SYNC3, PDF_K_SYNC1, PDF_K_SYNC3, PDF_K_SYNC1};
      PDF_SOP1_D: return {PDF_K_SYNC3, PDF_K_RST2, PDF_K_RST2, PDF_K_SYNC1};
      PDF_SOP2_D: return {PDF_K_SYNC2, PDF_K_SYNC3, PDF_K_RST2, PDF_K_SYNC1};
      default:    return {PDF_K_SYNC2, PDF_K_SYNC1, PDF_K_SYNC1, PDF_K_SYNC1};
    endcase
  endfunction
  // Whole frame as symbols; a set bad bit puts a wrong K-code there
  function automatic void build(input logic [15:0] os, input int n, input logic [3:0] bad,
                                input logic flip);
    logic [31:0] c;
    logic [31:0] f;
    exp_q = {};
    for (int i = 0; i < 4; i++) exp_q.push_back({1'b1, bad[i] ? PDF_K_RST1 : os[4*i+:4]});
    c = PDF_CRC_INIT;
    for (int i = 0; i < n; i++) begin
      exp_q.push_back({1'b0, pl[i][3:0]});
      exp_q.push_back({1'b0, pl[i][7:4]});
      for (int k = 0; k < 8; k++) c = {c[30:0], 1'b0} ^ ((c[31] ^ pl[i][k]) ? PDF_CRC_POLY : '0);
    end
    f = {<<{~c}};
    f[0] = f[0] ^ flip;
    for (int i = 0; i < 8; i++) exp_q.push_back({1'b0, f[4*i+:4]});
    exp_q.push_back({1'b1, PDF_K_EOP});
  endfunction
  task automatic send(input pdf_sop_t t, input int n);
    int w;
    @(posedge clk);
    tx_start <= 1'b1;
    tx_sop   <= t;
    @(posedge clk);
    tx_start <= 1'b0;
    for (int i = 0; i < n; i++) begin
      tx_valid <= 1'b1;
      tx_byte  <= '{pl[i], i == n - 1};
      w = 0;
      do begin
        @(posedge clk);
        w++;
      end while (tx_ready !== 1'b1 && w < 100);
    end
    tx_valid <= 1'b0;
  endtask
  task automatic wait_idle;
    int w = 0;
    do begin
      @(posedge clk);
      w++;
    end while (tx_busy !== 1'b0 && w < 400);
    chk(tx_busy, 1'b0, "tx back to idle");
    repeat (3) @(posedge clk);
  endtask
  // *****
  // Scenarios
  // *****
  task automatic t_tx(input pdf_sop_t t, input int n, input logic s);
    @(posedge clk);
    cfg  <= C_DFP;
    slow <= s;
    u_line.tx_q.delete();
    build(os_of(t), n, 4'h0, 1'b0);
    send(t, n);
    wait_idle();
    chk(u_line.tx_q.size(), exp_q.size(), "tx length");
    foreach (exp_q[i]) chk(u_line.tx_q[i], exp_q[i], "tx symbol");
  endtask
  task automatic t_ref(input pdf_cfg_t c, input pdf_sop_t t);
    @(posedge clk);
    cfg <= c;
    send(t, 0);
    #1;
    chk(tx_refused, 1'b1, "start refused");
    chk(sym_out_valid, 1'b0, "nothing sent");
  endtask
  task automatic t_abort;
    @(posedge clk);
    cfg  <= C_DFP;
    slow <= 1'b0;
    u_line.tx_q.delete();
    send(PDF_SOP, 1);
    @(posedge clk);
    tx_abort <= 1'b1;
    @(posedge clk);
    tx_abort <= 1'b0;
    wait_idle();
    chk(u_line.tx_q[$], {1'b1, PDF_K_EOP}, "abort end");
    chk(u_line.tx_q.size() < 15, 1'b1, "cut short");
    chk(u_line.tx_q[u_line.tx_q.size() - 2].is_k, 1'b0, "single end");
  endtask
  // Line goes idle mid-packet: reported bad, nothing delivered
  task automatic t_cut;
    @(posedge clk);
    cfg <= C_DFP;
    build(os_of(PDF_SOP), 4, 4'h0, 1'b0);
    rx_got = {};
    n_good = 0;
    n_bad  = 0;
    for (int i = 0; i < 10; i++) u_line.rx_q.push_back(exp_q[i]);
    repeat (16) @(posedge clk);
    rx_idle <= 1'b1;
    @(posedge clk);
    rx_idle <= 1'b0;
    repeat (4) @(posedge clk);
    chk(n_bad, 1, "idle cut bad count");
    chk(n_good, 0, "idle cut good count");
    chk(rx_got.size(), 0, "idle cut bytes");
  endtask
  // ex: 0 dropped silently, 1 delivered, 2 reported bad
  task automatic t_rx(input pdf_cfg_t c, input pdf_sop_t t, input logic [3:0] bad,
                      input logic flip, input int ex);
    @(posedge clk);
    cfg <= c;
    build(os_of(t), 4, bad, flip);
    rx_got = {};
    n_good = 0;
    n_bad  = 0;
    repeat (2) @(posedge clk);
    foreach (exp_q[i]) u_line.rx_q.push_back(exp_q[i]);
    repeat (60) @(posedge clk);
    chk(n_good, ex == 1, "rx good count");
    chk(n_bad, ex == 2, "rx bad count");
    if (ex != 2) chk(rx_got.size(), ex == 1 ? 4 : 0, "rx byte count");
    if (ex == 1) chk(rx_sop, t, "rx start type");
    if (ex == 1) foreach (rx_got[i]) chk(rx_got[i], pl[i], "rx byte");
  endtask
  initial begin
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    #1;
    chk(rx_sop, PDF_NONE, "reset start type");
    t_tx(PDF_SOP, 1, 1'b0);
    t_tx(PDF_SOP1, 5, 1'b1);
    t_tx(PDF_SOP2, 4, 1'b0);
    t_ref(C_UFP, PDF_SOP1);
    t_ref(C_UFP, PDF_SOP2);
    t_ref(C_SNK, PDF_SOP1);
    t_ref(C_DFP, PDF_SOP1_D);
    t_ref(C_DFP, PDF_SOP2_D);
    t_abort();
    t_rx(C_DFP, PDF_SOP, 4'h0, 1'b0, 1);
    t_rx(C_DFP, PDF_SOP, 4'h1, 1'b0, 1);
    t_rx(C_DFP, PDF_SOP1, 4'h8, 1'b0, 1);
    t_rx(C_DFP, PDF_SOP, 4'ha, 1'b0, 0);
    t_rx(C_DFP, PDF_SOP, 4'h0, 1'b1, 2);
    t_rx(C_P1, PDF_SOP, 4'h0, 1'b0, 0);
    t_rx(C_P1, PDF_SOP1, 4'h0, 1'b0, 1);
    t_rx(C_P2, PDF_SOP1, 4'h0, 1'b0, 0);
    t_rx(C_P2, PDF_SOP2, 4'h0, 1'b0, 1);
    t_rx(C_UFP, PDF_SOP1, 4'h0, 1'b0, 0);
    t_rx(C_UFP, PDF_SOP2, 4'h0, 1'b0, 0);
    t_rx(C_SNK, PDF_SOP1, 4'h0, 1'b0, 0);
    t_rx(C_DFP, PDF_SOP1_D, 4'h0, 1'b0, 0);
    t_rx(C_DFP, PDF_SOP2, 4'h0, 1'b0, 1);
    t_cut();
    end_sim();
  end
  // Tests need about 1200 cycles; twenty times that covers stalls
  initial begin
    repeat (25000) @(posedge clk);
    mismatches++;
    end_sim();
  end
endmodule
`default_nettype wire
